// File: rtl/lesf_pkg.sv
package lesf_pkg;
   // Byte addresses of the register words
   localparam logic [7:0] LESF_ADDR_FLAGS = 8'h00;
   localparam logic [7:0] LESF_ADDR_CLEAR = 8'h04;
   localparam logic [7:0] LESF_ADDR_ENABLE = 8'h08;
   localparam logic [7:0] LESF_ADDR_RAW = 8'h0c;
   // Field positions inside the flag byte, and the field count
   localparam int LESF_BIT_AMP = 7;
   localparam int LESF_BIT_TXJ = 6;
   localparam int LESF_BIT_RXJ = 5;
   localparam int LESF_NUM_EV = 3;
   // Reset values and the flag mask
   localparam logic [7:0] LESF_FLAGS_RST = 8'h00;
   localparam logic [7:0] LESF_ENABLE_RST = 8'he0;
   localparam logic [7:0] LESF_FLAG_MASK = 8'he0;
   // Address width used by the slave
   localparam int LESF_AW = 8;
endpackage : lesf_pkg

// File: rtl/lesf_ev_if.sv
`timescale 1ns/1ps
`default_nettype none
// Event strobes and flag state between the core and the flag module
interface lesf_ev_if;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic [7:0] flags;
   modport core (output set_vec, output clr_vec, input flags);
   modport bank (input set_vec, input clr_vec, output flags);
endinterface : lesf_ev_if
`default_nettype wire

// File: rtl/lesf_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky flag byte: set wins over a clear in the same cycle
module lesf_flag_bank (
   input wire logic i_clock,
   input wire logic i_nrst,
   lesf_ev_if.bank ev
);
   import lesf_pkg::*;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;

   // Set has priority so an event in the clearing cycle is kept
   assign flags_next = ((flags_reg & ~ev.clr_vec) | ev.set_vec)
      & LESF_FLAG_MASK;

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         flags_reg <= LESF_FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign ev.flags = flags_reg;
endmodule : lesf_flag_bank
`default_nettype wire

// File: rtl/lesf_top.sv
`timescale 1ns/1ps
`default_nettype none
module lesf_top (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [lesf_pkg::LESF_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_amplitude_overflow,
   input wire logic i_tx_jitter_fifo_ovf,
   input wire logic i_tx_jitter_fifo_unf,
   input wire logic i_rx_jitter_fifo_ovf,
   input wire logic i_rx_jitter_fifo_unf,
   output logic o_irq
);
   import lesf_pkg::*;

   lesf_ev_if ev ();

   logic [7:0] enable_reg;
   logic [7:0] enable_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [LESF_NUM_EV-1:0] ev_sync1_reg;
   logic [LESF_NUM_EV-1:0] ev_sync2_reg;
   logic [LESF_NUM_EV-1:0] ev_prev_reg;
   logic [LESF_NUM_EV-1:0] ev_raw;
   logic [LESF_NUM_EV-1:0] ev_rise;

   // Event sources sit outside this clock, so synchronise them first
   assign ev_raw = {i_amplitude_overflow,
                    i_tx_jitter_fifo_ovf | i_tx_jitter_fifo_unf,
                    i_rx_jitter_fifo_ovf | i_rx_jitter_fifo_unf};

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ev_sync1_reg <= '0;
         ev_sync2_reg <= '0;
         ev_prev_reg <= '0;
      end else begin
         ev_sync1_reg <= ev_raw;
         ev_sync2_reg <= ev_sync1_reg;
         ev_prev_reg <= ev_sync2_reg;
      end
   end

   // Rising edge only: a held level flags once, not after every clear
   assign ev_rise = ev_sync2_reg & ~ev_prev_reg;

   // Flag set vector, one bit per documented field
   assign ev.set_vec[LESF_BIT_AMP] = ev_rise[2];
   assign ev.set_vec[LESF_BIT_TXJ] = ev_rise[1];
   assign ev.set_vec[LESF_BIT_RXJ] = ev_rise[0];
   assign ev.set_vec[4:0] = 5'h00;

   // APB decode; zero wait states so pready is always high
   logic wr_en;
   logic hit_flags;
   logic hit_clear;
   logic hit_enable;
   logic hit_raw;
   logic hit_any;
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign hit_flags = (i_paddr == LESF_ADDR_FLAGS);
   assign hit_clear = (i_paddr == LESF_ADDR_CLEAR);
   assign hit_enable = (i_paddr == LESF_ADDR_ENABLE);
   assign hit_raw = (i_paddr == LESF_ADDR_RAW);
   assign hit_any = hit_flags | hit_clear | hit_enable | hit_raw;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~hit_any;

   // Write-one-to-clear works at the flag word and the clear word
   assign ev.clr_vec = (wr_en & (hit_flags | hit_clear))
      ? (i_pwdata[7:0] & LESF_FLAG_MASK) : 8'h00;

   assign enable_next = (wr_en & hit_enable)
      ? (i_pwdata[7:0] & LESF_FLAG_MASK) : enable_reg;

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         enable_reg <= LESF_ENABLE_RST;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // Read mux; clear word is write-only and reads zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (i_psel & ~i_penable & ~i_pwrite) begin
         if (hit_flags) begin
            rdata_next = {24'h00_0000, ev.flags};
         end else if (hit_enable) begin
            rdata_next = {24'h00_0000, enable_reg};
         end else if (hit_raw) begin
            rdata_next = {24'h00_0000, ev_sync2_reg, 5'h00};
         end else begin
            rdata_next = 32'h0000_0000;
         end
      end else begin
         rdata_next = rdata_reg;
      end
   end

   // Data captured in setup so the access phase returns a register
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign o_prdata = rdata_reg;

   lesf_flag_bank u_bank (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .ev(ev)
   );

   // Level interrupt while any enabled flag stands
   assign o_irq = |(ev.flags & enable_reg);
endmodule : lesf_top
`default_nettype wire

// File: dv/lesf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lesf_chk (
   input wire logic i_clock, i_nrst, i_psel, i_penable, i_pwrite,
   input wire logic [lesf_pkg::LESF_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_amplitude_overflow, i_tx_jitter_fifo_ovf,
   input wire logic i_tx_jitter_fifo_unf, i_rx_jitter_fifo_ovf,
   input wire logic i_rx_jitter_fifo_unf, o_irq);
   logic [2:0] quiet_reg;
   wire any_ev = i_amplitude_overflow | i_tx_jitter_fifo_ovf |
      i_tx_jitter_fifo_unf | i_rx_jitter_fifo_ovf | i_rx_jitter_fifo_unf;
   wire wr = i_psel & i_penable & i_pwrite;
   // Quiet count: a late event rise must not race a clear
   always_ff @(posedge i_clock)
      quiet_reg <= (!i_nrst || any_ev) ? 3'h0 :
         quiet_reg + {2'h0, quiet_reg != 3'h7};
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   property p_amp; $rose(i_amplitude_overflow) |-> ##[1:5] o_irq; endproperty
   a_amp: assert property (p_amp) else $error("amp no irq");
   property p_txj; $rose(i_tx_jitter_fifo_ovf) |-> ##[1:5] o_irq; endproperty
   a_txj: assert property (p_txj) else $error("tx no irq");
   property p_rxj; $rose(i_rx_jitter_fifo_ovf) |-> ##[1:5] o_irq; endproperty
   a_rxj: assert property (p_rxj) else $error("rx no irq");
   property p_clr; wr && i_paddr == 8'h04 && i_pwdata[7:5] == 3'h7 &&
      quiet_reg == 3'h7 |=> !o_irq; endproperty
   a_clr: assert property (p_clr) else $error("clear kept irq");
   property p_rst; $rose(i_nrst) |-> !o_irq; endproperty
   a_rst: assert property (p_rst) else $error("irq after reset");
   property p_hold; o_irq && !wr |=> o_irq; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   c_rise: cover property ($rose(o_irq));
   c_fall: cover property ($fell(o_irq));
   c_clr: cover property (p_clr);
endmodule : lesf_chk
bind lesf_top lesf_chk i_chk (.*);
`default_nettype wire

// File: dv/lesf_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lesf_top_bench;
   logic i_clock = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0, irq, rdy;
   logic slverr, err;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0, rdata, r;
   logic [4:0] evs = 0;
   int fail_count = 0, check_count = 0, cyc = 0;
   lesf_top i_lesf_top (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
      .o_prdata(rdata), .o_pready(rdy), .o_pslverr(slverr),
      .i_amplitude_overflow(evs[0]), .i_tx_jitter_fifo_ovf(evs[1]),
      .i_tx_jitter_fifo_unf(evs[2]), .i_rx_jitter_fifo_ovf(evs[3]),
      .i_rx_jitter_fifo_unf(evs[4]), .o_irq(irq));
   initial forever #4 i_clock = ~i_clock;
   // Hang guard
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(string n, logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // APB transfer; waits on pready, then lets updates land
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge i_clock);
      psel <= 1; pwr <= w; addr <= a; wdata <= d;
      @(posedge i_clock);
      pen <= 1;
      do @(posedge i_clock); while (rdy !== 1'b1);
      r = rdata;
      err = slverr;
      psel <= 0; pen <= 0;
      #1;
   endtask : bus
   task automatic pulse(int k);
      @(posedge i_clock);
      evs[k] <= 1;
      repeat (8) @(posedge i_clock);
      evs[k] <= 0;
      repeat (8) @(posedge i_clock);
   endtask : pulse
   task automatic close_out;
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (2) @(posedge i_clock);
      i_nrst <= 1;
      bus(0, 8'h08, 0); chk("enable", 32'he0, r);
      bus(0, 8'h00, 0); chk("flags", 0, r);
      for (int k = 0; k < 5; k++) begin
         pulse(k);
         bus(0, 8'h00, 0);
         chk("flag", 32'h80 >> ((k + 1) / 2), r);
         chk("irq", 1, irq);
         bus(1, 8'h04, 32'hff);
         bus(0, 8'h00, 0); chk("cleared", 0, r);
         $display("event %0d done", k);
      end
      // Masked event still latches but stays off the pin
      bus(1, 8'h08, 0); pulse(2); chk("masked", 0, irq);
      bus(0, 8'h00, 0); chk("latched", 32'h40, r);
      chk("mapped_err", 0, err);
      bus(1, 8'h08, 32'he0); chk("unmasked", 1, irq);
      bus(1, 8'h00, 32'h40); chk("w1c", 0, irq);
      bus(0, 8'h10, 0); chk("unmapped", 0, r);
      chk("pslverr", 1, err);
      $display("mask test done");
      close_out();
   end
endmodule : lesf_top_bench
`default_nettype wire
